// ==== spi_flash_id_dev.sv ====
// flash front end: id reads, hold and write-command guard
// ==========================================================
// Behaviour
// - 9Fh returns maker, type, capacity, reserved
// - 9Fh four-byte sequence repeats while clocked
// - both id reads ignored while write busy
// - ABh plus 24 dummy bits returns id
// - short id byte repeats while clocked
// - id out on falling edges, ended by cs
// - hold enters low-clock, leaves on rising
// - host changes hold only while clock low
// - hold needs cs low, cs rise resets
// - held: output released, clock and data ignored
// - host waits 100 us before first command
// - standby after reset, power-down only commanded
// - write discarded unless cs rises on byte
// - page program needs whole data bytes
// - status write of excess cycles rejected
// - power-down accepts only ABh and exit
// - an ABh command byte leaves power-down
`timescale 1ns/1ps
`include "spi_flash_id_cfg.svh"
`default_nettype none
module spi_flash_id_dev #(
  parameter logic [7:0] MANUF_ID = `ID_MANUF,
  parameter logic [7:0] MEM_TYPE = `ID_MEMTYPE,
  parameter logic [7:0] CAPACITY = `ID_CAPACITY,
  parameter logic [7:0] RESERVED = `ID_RESERVED,
  parameter logic [7:0] SHORT_ID = `ID_SHORT
) (
  // system side
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic writeBusy,
  // command results
  output logic powerDown,
  output logic writeGo,
  output logic writeDrop,
  output logic [7:0] writeCode,
  // serial link
  spi_link_if.dev link
);
  // ==========================================================
  // helpers
  function automatic logic idBit(input logic [7:0] b, input logic [2:0] n);
    idBit = b[`BIT_LAST - n];
  endfunction : idBit

  function automatic logic isWriteCmd(input logic [7:0] c);
    case (c)
      `CMD_WREN, `CMD_WRDI, `CMD_WRSR, `CMD_PAGE_PROG, `CMD_ERASE_SS, `CMD_ERASE_SS2,
      `CMD_ERASE_SEC, `CMD_ERASE_CHIP, `CMD_ERASE_CHIP2: isWriteCmd = 1'b1;
      default: isWriteCmd = 1'b0;
    endcase
  endfunction : isWriteCmd

  // ==========================================================
  // link domain, clocked by the serial clock
  spi_flash_id_pkg::link_state_e state_reg;
  logic [2:0] bitCnt_reg;
  logic [2:0] byteCnt_reg;
  logic [6:0] shiftIn_reg;
  logic [1:0] idSel_reg;
  logic [1:0] busySync_reg;
  logic [1:0] pdSync_reg;
  logic midByte_reg;
  logic [7:0] lastByte_reg;
  logic byteTgl_reg;
  logic soBit_reg;
  logic soOeN_reg;
  logic byteDone;
  logic [7:0] byteIn;
  logic quiet;
  logic [7:0] jedecByte;

  assign byteDone = bitCnt_reg == `BIT_LAST;
  assign byteIn = {shiftIn_reg, link.si};
  // held or deselected: the output side is forced quiet at once
  assign quiet = link.csN | ~link.holdN;

  // busy changes only between frames, power-down at a frame end or just after an ABh command byte; the clock edges of the
  // command byte are enough to settle these synchronisers
  always_ff @(posedge link.sclk) begin
    busySync_reg <= {busySync_reg[0], writeBusy};
    pdSync_reg <= {pdSync_reg[0], powerDown};
  end

  // hold is stable at every rising edge because the host moves it only
  // while the clock is low, so sampling it here gates whole edges
  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      bitCnt_reg <= 3'h0;
      shiftIn_reg <= 7'h0;
    end else if (link.holdN) begin
      bitCnt_reg <= bitCnt_reg + 3'h1;
      shiftIn_reg <= {shiftIn_reg[5:0], link.si};
    end
  end

  always_ff @(posedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      state_reg <= spi_flash_id_pkg::LS_CMD;
      byteCnt_reg <= 3'h0;
      idSel_reg <= 2'h0;
    end else if (link.holdN && byteDone) begin
      if (byteCnt_reg != `BYTE_CNT_MAX) begin
        byteCnt_reg <= byteCnt_reg + 3'h1;
      end
      case (state_reg)
        spi_flash_id_pkg::LS_CMD: begin
          if (busySync_reg[1]) begin
            state_reg <= spi_flash_id_pkg::LS_SKIP;
          end else if (byteIn == `CMD_JEDEC_ID && !pdSync_reg[1]) begin
            state_reg <= spi_flash_id_pkg::LS_JEDEC;
          end else if (byteIn == `CMD_SHORT_ID) begin
            state_reg <= spi_flash_id_pkg::LS_ADDR;
          end else begin
            state_reg <= spi_flash_id_pkg::LS_SKIP;
          end
        end
        spi_flash_id_pkg::LS_JEDEC: idSel_reg <= idSel_reg + 2'h1;
        spi_flash_id_pkg::LS_ADDR: begin
          if (byteCnt_reg == `ID_DUMMY_LAST) begin
            state_reg <= spi_flash_id_pkg::LS_SHORT;
          end
        end
        spi_flash_id_pkg::LS_SHORT: state_reg <= spi_flash_id_pkg::LS_SHORT;
        default: state_reg <= spi_flash_id_pkg::LS_SKIP;
      endcase
    end
  end

  // frame summary for the system side; survives the cs rise on purpose
  always_ff @(posedge link.sclk or negedge rst_n) begin
    if (!rst_n) begin
      midByte_reg <= 1'b0;
      lastByte_reg <= 8'h00;
      byteTgl_reg <= 1'b0;
    end else if (link.holdN) begin
      midByte_reg <= !byteDone;
      if (byteDone) begin
        lastByte_reg <= byteIn;
        byteTgl_reg <= ~byteTgl_reg;
      end
    end
  end

  always_comb begin
    case (idSel_reg)
      2'h0: jedecByte = MANUF_ID;
      2'h1: jedecByte = MEM_TYPE;
      2'h2: jedecByte = CAPACITY;
      default: jedecByte = RESERVED;
    endcase
  end

  // data leaves on falling edges, msb first; a hold keeps the pending bit
  // so it can be driven again the moment hold rises
  always_ff @(negedge link.sclk or posedge link.csN) begin
    if (link.csN) begin
      soOeN_reg <= 1'b1;
      soBit_reg <= 1'b0;
    end else if (link.holdN) begin
      case (state_reg)
        spi_flash_id_pkg::LS_JEDEC: begin
          soBit_reg <= idBit(jedecByte, bitCnt_reg);
          soOeN_reg <= 1'b0;
        end
        spi_flash_id_pkg::LS_SHORT: begin
          soBit_reg <= idBit(SHORT_ID, bitCnt_reg);
          soOeN_reg <= 1'b0;
        end
        default: soOeN_reg <= 1'b1;
      endcase
    end
  end

  assign link.so = soBit_reg;
  // no serial clock runs while held, so only a gate can release the line
  assign link.soOeN = soOeN_reg | quiet;

  // ==========================================================
  // system domain
  logic [1:0] csSync_reg;
  logic [1:0] tglSync_reg;
  logic tglSeen_reg;
  logic csD1_reg;
  logic csD2_reg;
  logic [3:0] frameBytes_reg;
  logic [7:0] frameCmd_reg;
  logic byteEvt;
  logic frameEnd;
  logic writeOk;
  logic isWrite;

  assign byteEvt = tglSync_reg[1] ^ tglSeen_reg;
  // one cycle later than the synchronised cs so a last byte lands first
  assign frameEnd = csD1_reg & ~csD2_reg;
  assign isWrite = frameBytes_reg != 4'h0 && isWriteCmd(frameCmd_reg);

  always_comb begin
    writeOk = !midByte_reg;
    if (frameCmd_reg == `CMD_PAGE_PROG && frameBytes_reg < `PP_MIN_BYTES) begin
      writeOk = 1'b0;
    end
    if (frameCmd_reg == `CMD_WRSR && frameBytes_reg >= `WRSR_REJECT_BYTES) begin
      writeOk = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      csSync_reg <= 2'b11;
      tglSync_reg <= 2'b00;
      tglSeen_reg <= 1'b0;
      csD1_reg <= 1'b1;
      csD2_reg <= 1'b1;
    end else if (ce) begin
      csSync_reg <= {csSync_reg[0], link.csN};
      tglSync_reg <= {tglSync_reg[0], byteTgl_reg};
      tglSeen_reg <= tglSync_reg[1];
      csD1_reg <= csSync_reg[1];
      csD2_reg <= csD1_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      frameBytes_reg <= 4'h0;
      frameCmd_reg <= 8'h00;
    end else if (ce) begin
      if (frameEnd) begin
        frameBytes_reg <= 4'h0;
      end else if (byteEvt) begin
        if (frameBytes_reg == 4'h0) begin
          frameCmd_reg <= lastByte_reg;
        end
        if (frameBytes_reg != `FRAME_CNT_MAX) begin
          frameBytes_reg <= frameBytes_reg + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      powerDown <= 1'b0;
    end else if (ce) begin
      if (byteEvt && frameBytes_reg == 4'h0 && lastByte_reg == `CMD_PD_EXIT) begin
        powerDown <= 1'b0;
      end else if (frameEnd && !powerDown && frameCmd_reg == `CMD_PD_ENTER
                   && frameBytes_reg == 4'h1 && !midByte_reg && !writeBusy) begin
        powerDown <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      writeGo <= 1'b0;
      writeDrop <= 1'b0;
      writeCode <= 8'h00;
    end else if (ce) begin
      writeGo <= frameEnd && isWrite && !powerDown && writeOk;
      writeDrop <= frameEnd && isWrite && (powerDown || !writeOk);
      if (frameEnd && isWrite) begin
        writeCode <= frameCmd_reg;
      end
    end
  end
endmodule : spi_flash_id_dev
`default_nettype wire

// ==== spi_flash_id_cfg.svh ====
// constants shared by both ends of the serial flash id/hold link
`ifndef SPI_FLASH_ID_CFG_SVH
`define SPI_FLASH_ID_CFG_SVH
// command codes
`define CMD_JEDEC_ID 8'h9f
`define CMD_SHORT_ID 8'hab
`define CMD_PD_EXIT 8'hab
`define CMD_PD_ENTER 8'hb9
`define CMD_WREN 8'h06
`define CMD_WRDI 8'h04
`define CMD_WRSR 8'h01
`define CMD_PAGE_PROG 8'h02
`define CMD_ERASE_SS 8'h20
`define CMD_ERASE_SS2 8'hd7
`define CMD_ERASE_SEC 8'hd8
`define CMD_ERASE_CHIP 8'h60
`define CMD_ERASE_CHIP2 8'hc7
// identity codes, values arbitrary
`define ID_MANUF 8'ha5
`define ID_MEMTYPE 8'h5a
`define ID_CAPACITY 8'h3c
`define ID_RESERVED 8'hc3
`define ID_SHORT 8'h96
// framing
`define BIT_LAST 3'h7
`define BYTE_CNT_MAX 3'h7
`define ID_DUMMY_LAST 3'h3
`define FRAME_CNT_MAX 4'hf
`define PP_MIN_BYTES 4'h5
`define WRSR_REJECT_BYTES 4'h3
// timing
`define POWERUP_WAIT_US 100
`define SYS_CLK_MHZ 250
`define SCK_HALF_CYCLES 4'h4
// buffering
`define FIFO_WIDTH 9
`define FIFO_DEPTH 8
`endif

// ==== spi_flash_id_pkg.sv ====
// types shared by both ends of the serial flash id/hold link
package spi_flash_id_pkg;
  typedef enum logic [2:0] {LS_CMD, LS_JEDEC, LS_ADDR, LS_SHORT, LS_SKIP} link_state_e;
  typedef enum logic [2:0] {HS_PWRUP, HS_IDLE, HS_SHIFT, HS_NEXT, HS_END} host_state_e;
endpackage : spi_flash_id_pkg

// ==== spi_link_if.sv ====
// serial link between the flash front end and its host controller
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic csN;
  logic si;
  logic holdN;
  logic so;
  logic soOeN;
  logic soLine;
  // released data line floats high through a pull-up
  assign soLine = soOeN ? 1'b1 : so;
  modport dev (input sclk, input csN, input si, input holdN, output so, output soOeN);
  modport host (output sclk, output csN, output si, output holdN, input soLine);
endinterface : spi_link_if
`default_nettype wire

// ==== spi_flash_id_host.sv ====
// host controller end of the serial flash link, with its command fifo
`timescale 1ns/1ps
`include "spi_flash_id_cfg.svh"
`default_nettype none
// ==========================================================
// fifo
module spi_cmd_fifo #(
  parameter int WIDTH = `FIFO_WIDTH,
  parameter int DEPTH = `FIFO_DEPTH
) (
  // clock
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign count = wrPtr_reg - rdPtr_reg;
  assign inReady = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign outData = mem[rdPtr_reg[AW-1:0]];
  assign push = ce && inValid && inReady;
  assign pop = ce && outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule : spi_cmd_fifo

// ==========================================================
// host engine
module spi_flash_id_host #(
  parameter int unsigned POWERUP_CYCLES = `POWERUP_WAIT_US * `SYS_CLK_MHZ
) (
  // system side
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  // byte stream out, last closes the frame
  input wire logic txValid,
  output logic txReady,
  input wire logic [7:0] txData,
  input wire logic txLast,
  // byte stream in
  output logic rxValid,
  output logic [7:0] rxData,
  // control and status
  input wire logic holdReq,
  output logic linkReady,
  // serial link
  spi_link_if.host link
);
  spi_flash_id_pkg::host_state_e state_reg;
  logic [31:0] waitCnt_reg;
  logic [3:0] halfCnt_reg;
  logic [2:0] bitIdx_reg;
  logic [7:0] txShift_reg;
  logic [7:0] rxShift_reg;
  logic last_reg;
  logic sclk_reg;
  logic csN_reg;
  logic si_reg;
  logic holdN_reg;
  logic [1:0] soSync_reg;
  logic fifoValid;
  logic fifoTake;
  logic [8:0] fifoData;
  logic paused;

  // nothing is queued out before the power-up wait has passed
  assign fifoTake = fifoValid && (state_reg == spi_flash_id_pkg::HS_IDLE
                    || state_reg == spi_flash_id_pkg::HS_NEXT) && !holdReq;
  assign paused = !sclk_reg && (holdReq || !holdN_reg);

  spi_cmd_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) cmdFifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .inValid(txValid),
    .inReady(txReady),
    .inData({txLast, txData}),
    .outValid(fifoValid),
    .outReady(fifoTake),
    .outData(fifoData)
  );

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      soSync_reg <= 2'b11;
    end else if (ce) begin
      soSync_reg <= {soSync_reg[0], link.soLine};
    end
  end

  // hold only moves while the clock is low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      holdN_reg <= 1'b1;
    end else if (ce && !sclk_reg && !csN_reg) begin
      holdN_reg <= !holdReq;
    end else if (ce && csN_reg) begin
      holdN_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= spi_flash_id_pkg::HS_PWRUP;
      waitCnt_reg <= 32'h0000_0000;
      halfCnt_reg <= 4'h0;
      bitIdx_reg <= 3'h0;
      txShift_reg <= 8'h00;
      rxShift_reg <= 8'h00;
      last_reg <= 1'b0;
      sclk_reg <= 1'b0;
      csN_reg <= 1'b1;
      si_reg <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      linkReady <= 1'b0;
    end else if (ce) begin
      rxValid <= 1'b0;
      if (fifoTake) begin
        txShift_reg <= fifoData[7:0];
        si_reg <= fifoData[7];
        last_reg <= fifoData[8];
        csN_reg <= 1'b0;
        bitIdx_reg <= 3'h0;
        halfCnt_reg <= 4'h0;
        state_reg <= spi_flash_id_pkg::HS_SHIFT;
      end else begin
        case (state_reg)
          spi_flash_id_pkg::HS_PWRUP: begin
            if (waitCnt_reg == POWERUP_CYCLES - 1) begin
              state_reg <= spi_flash_id_pkg::HS_IDLE;
              linkReady <= 1'b1;
            end else begin
              waitCnt_reg <= waitCnt_reg + 32'h0000_0001;
            end
          end
          spi_flash_id_pkg::HS_SHIFT: begin
            if (!paused) begin
              if (halfCnt_reg == `SCK_HALF_CYCLES - 4'h1) begin
                halfCnt_reg <= 4'h0;
                sclk_reg <= !sclk_reg;
                if (!sclk_reg) begin
                  rxShift_reg <= {rxShift_reg[6:0], soSync_reg[1]};
                end else if (bitIdx_reg == `BIT_LAST) begin
                  rxValid <= 1'b1;
                  rxData <= rxShift_reg;
                  state_reg <= last_reg ? spi_flash_id_pkg::HS_END : spi_flash_id_pkg::HS_NEXT;
                end else begin
                  bitIdx_reg <= bitIdx_reg + 3'h1;
                  txShift_reg <= {txShift_reg[6:0], 1'b0};
                  si_reg <= txShift_reg[6];
                end
              end else begin
                halfCnt_reg <= halfCnt_reg + 4'h1;
              end
            end else begin
              // restart the low phase so the re-driven bit reaches the sampler
              halfCnt_reg <= 4'h0;
            end
          end
          spi_flash_id_pkg::HS_END: begin
            if (halfCnt_reg == `SCK_HALF_CYCLES - 4'h1) begin
              halfCnt_reg <= 4'h0;
              csN_reg <= 1'b1;
              if (csN_reg) begin
                // a full half period deselected before the next frame
                state_reg <= spi_flash_id_pkg::HS_IDLE;
              end
            end else begin
              halfCnt_reg <= halfCnt_reg + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  assign link.sclk = sclk_reg;
  assign link.csN = csN_reg;
  assign link.si = si_reg;
  assign link.holdN = holdN_reg;
endmodule : spi_flash_id_host
`default_nettype wire

// ==== spi_flash_id_checker.sv ====
// concurrent checks on the serial link between flash front end and host
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_id_cfg.svh"
module spi_flash_id_checker (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic csN,
  input wire logic si,
  input wire logic holdN,
  input wire logic so,
  input wire logic soOeN,
  input wire logic soLine
);
  localparam logic [31:0] JEDEC_SEQ = {`ID_MANUF, `ID_MEMTYPE, `ID_CAPACITY, `ID_RESERVED};
  localparam logic [7:0] SHORT_SEQ = `ID_SHORT;
  logic [15:0] riseCnt;
  logic [7:0] cmdReg;
  logic [4:0] jIdx;
  logic [2:0] sIdx;
  // ==========================================================
  // helper: unheld rising edges of the frame and its command byte
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) riseCnt <= 16'h0000;
    else if (holdN) riseCnt <= riseCnt + 16'h0001;
  end
  always_ff @(posedge sclk or posedge csN) begin
    if (csN) cmdReg <= 8'h00;
    else if (holdN && riseCnt < 16'h0008) cmdReg <= {cmdReg[6:0], si};
  end
  // truncation gives the wrap of the repeating id streams for free
  assign jIdx = 5'(riseCnt - 16'h0008);
  assign sIdx = 3'(riseCnt - 16'h0020);
  // ==========================================================
  // sequences
  sequence clkHighPhase;
    sclk [*4] ##1 !sclk;
  endsequence
  sequence csGap;
    csN [*4];
  endsequence
  // ==========================================================
  // assertions
  a_jedec_bits: assert property (@(posedge sclk) disable iff (csN || !rst_n)
    (!soOeN && cmdReg == 8'h9f && riseCnt >= 16'h0008) |-> so == JEDEC_SEQ[~jIdx])
    else $error("jedec id bit wrong");
  a_short_bits: assert property (@(posedge sclk) disable iff (csN || !rst_n)
    (!soOeN && cmdReg == 8'hab && riseCnt >= 16'h0020) |-> so == SHORT_SEQ[~sIdx])
    else $error("short id bit wrong");
  a_out_on_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!soOeN && $past(!soOeN) && $changed(so)) |-> $fell(sclk))
    else $error("data out moved off a falling clock");
  a_sclk_half: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(sclk) |-> clkHighPhase)
    else $error("serial clock high phase wrong");
  a_hold_change: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $changed(holdN) |-> !sclk)
    else $error("hold moved while clock high");
  a_held_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !holdN |-> !sclk)
    else $error("clock ran while held");
  a_hold_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!holdN && $past(!holdN)) |-> soOeN)
    else $error("data out driven while held");
  a_cs_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (csN && $past(csN)) |-> (soOeN && soLine))
    else $error("data out driven while deselected");
  a_idle_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    csN |-> !sclk)
    else $error("clock not idle low while deselected");
  a_cs_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(csN) |-> csGap)
    else $error("deselect gap too short");
endmodule : spi_flash_id_checker
`default_nettype wire

// ==== test_spi_flash_id_hold_guard.sv ====
// self-checking bench: host engine and flash front end joined by the link
`timescale 1ns/1ps
`default_nettype none
module test_spi_flash_id_hold_guard;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b1;
  logic writeBusy = 1'b0;
  logic txValid = 1'b0;
  logic [7:0] txData = 8'h00;
  logic txLast = 1'b0;
  logic holdReq = 1'b0;
  logic holdChk = 1'b0;
  logic sawFull = 1'b0;
  logic txReady, rxValid, linkReady, powerDown, writeGo, writeDrop;
  logic [7:0] rxData, writeCode;
  logic [7:0] lastCode = 8'h00;
  logic [7:0] rxQ[$];
  int err_total = 0;
  int n_tests = 0;
  int goCnt = 0;
  int dropCnt = 0;
  int cycles = 0;
  int w;
  always #2 sys_clk = ~sys_clk;
  // ==========================================================
  // design
  spi_link_if spi_link_if_i ();
  spi_flash_id_dev spi_flash_id_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
    .writeBusy(writeBusy), .powerDown(powerDown), .writeGo(writeGo),
    .writeDrop(writeDrop), .writeCode(writeCode), .link(spi_link_if_i.dev));
  // short power-up wait keeps the run brief
  spi_flash_id_host #(.POWERUP_CYCLES(20)) spi_flash_id_host_i (.sys_clk(sys_clk),
    .rst_n(rst_n), .ce(1'b1), .txValid(txValid), .txReady(txReady), .txData(txData),
    .txLast(txLast), .rxValid(rxValid), .rxData(rxData), .holdReq(holdReq),
    .linkReady(linkReady), .link(spi_link_if_i.host));
  spi_flash_id_checker spi_flash_id_checker_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .sclk(spi_link_if_i.sclk), .csN(spi_link_if_i.csN), .si(spi_link_if_i.si),
    .holdN(spi_link_if_i.holdN), .so(spi_link_if_i.so), .soOeN(spi_link_if_i.soOeN),
    .soLine(spi_link_if_i.soLine));
  // ==========================================================
  // compare and report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // monitors and timeout
  always @(negedge sys_clk) begin
    if (rxValid === 1'b1) rxQ.push_back(rxData);
    if (writeGo === 1'b1) begin
      goCnt++;
      lastCode = writeCode;
    end
    if (writeDrop === 1'b1) begin
      dropCnt++;
      lastCode = writeCode;
    end
    if (holdChk && spi_link_if_i.holdN === 1'b0) chk_bit(spi_link_if_i.soLine, 1'b1);
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // ==========================================================
  // access tasks
  // sends one frame byte by byte, then compares the bytes read back
  task automatic run_frame(input logic [7:0] tx[$], input logic [7:0] rx[$]);
    int k;
    rxQ.delete();
    goCnt = 0;
    dropCnt = 0;
    foreach (tx[i]) begin
      @(negedge sys_clk);
      txValid = 1'b1;
      txData = tx[i];
      txLast = (i == tx.size() - 1);
      for (k = 0; k < 2000 && txReady !== 1'b1; k++) begin
        sawFull = 1'b1;
        @(negedge sys_clk);
      end
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    txValid = 1'b0;
    for (k = 0; k < 2000 && rxQ.size() < tx.size(); k++) @(negedge sys_clk);
    // frame decision lands about four cycles after deselect
    repeat (12) @(negedge sys_clk);
    foreach (rx[i]) chk_byte(rxQ[i], rx[i]);
  endtask : run_frame
  task automatic write_case(input logic [7:0] tx[$], input logic go);
    run_frame(tx, '{8'hff});
    chk_byte(8'(goCnt), {7'h00, go});
    chk_byte(8'(dropCnt), {7'h00, !go});
    chk_byte(lastCode, tx[0]);
  endtask : write_case
  // ==========================================================
  // tests
  initial begin
    // a real falling reset edge is needed to clear the serial-side flops
    #1 rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    for (w = 0; w < 200 && linkReady !== 1'b1; w++) @(negedge sys_clk);
    chk_bit(linkReady, 1'b1);
    chk_bit(powerDown, 1'b0);
    chk_bit(spi_link_if_i.soLine, 1'b1);
    $display("test reset done");
    // ten bytes overfill the fifo while a hold stalls the link mid-frame
    fork
      run_frame('{8'h9f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
        '{8'hff, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'ha5, 8'h5a, 8'h3c, 8'hc3, 8'ha5});
      begin
        repeat (150) @(negedge sys_clk);
        holdReq = 1'b1;
        holdChk = 1'b1;
        repeat (30) @(negedge sys_clk);
        chk_bit(spi_link_if_i.holdN, 1'b0);
        repeat (30) @(negedge sys_clk);
        holdReq = 1'b0;
        holdChk = 1'b0;
      end
    join
    chk_bit(sawFull, 1'b1);
    chk_bit(spi_link_if_i.holdN, 1'b1);
    $display("test jedec and hold done");
    run_frame('{8'hab, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
      '{8'hff, 8'hff, 8'hff, 8'hff, 8'h96, 8'h96});
    $display("test short id done");
    writeBusy = 1'b1;
    run_frame('{8'h9f, 8'h00}, '{8'hff, 8'hff});
    run_frame('{8'hab, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    writeBusy = 1'b0;
    $display("test busy done");
    write_case('{8'h06}, 1'b1);
    write_case('{8'h02, 8'h00, 8'h01, 8'h02, 8'h55}, 1'b1);
    write_case('{8'h02, 8'h00, 8'h01, 8'h02}, 1'b0);
    write_case('{8'h01, 8'h1c}, 1'b1);
    write_case('{8'h01, 8'h1c, 8'h1c}, 1'b0);
    $display("test write guard done");
    run_frame('{8'hb9}, '{8'hff});
    chk_bit(powerDown, 1'b1);
    run_frame('{8'h9f, 8'h00}, '{8'hff, 8'hff});
    write_case('{8'h06}, 1'b0);
    chk_bit(powerDown, 1'b1);
    run_frame('{8'hab, 8'h00, 8'h00, 8'h00, 8'h00}, '{8'hff, 8'hff, 8'hff, 8'hff, 8'h96});
    chk_bit(powerDown, 1'b0);
    $display("test power-down done");
    finish_test();
  end
endmodule : test_spi_flash_id_hold_guard
`default_nettype wire
